// ==== rtl/sacc_pkg.sv ====
// Shared constants and types for the converter conversion control block
package sacc_pkg;
  // Register offsets over the plain register port
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_CHAN = 4'h2;
  localparam logic [3:0] ADDR_REFGAIN = 4'h3;
  localparam logic [3:0] ADDR_RES_LOW = 4'h4;
  localparam logic [3:0] ADDR_RES_HIGH = 4'h5;
  localparam logic [3:0] ADDR_TRIG_FLAGS = 4'h6;
  // Control A fields
  localparam int CA_EN = 7;
  localparam int CA_START = 6;
  localparam int CA_AUTO = 5;
  localparam int CA_FLAG = 4;
  localparam int CA_IE = 3;
  localparam int CA_PS_LO = 0;
  // Control B fields
  localparam int CB_LEFT = 3;
  localparam int CB_TS_LO = 0;
  // Reference/gain field positions
  localparam int RG_GAIN_ACT = 7;
  // Trigger select code meaning the converter's own complete flag
  localparam logic [2:0] TS_SELF = 3'h0;
  // Conversion timing in converter clock cycles
  localparam logic [4:0] NORM_LEN = 5'h0f;
  localparam logic [4:0] NORM_SH = 5'h04;
  localparam logic [4:0] FIRST_LEN = 5'h1a;
  localparam logic [4:0] FIRST_SH = 5'h0f;
  localparam logic [7:0] RESET_VAL = 8'h00;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sacc_bus_type;

  typedef struct packed {
    logic [4:0] channel;
    logic [2:0] reference;
    logic sample;
  } sacc_front_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } sacc_state_type;
endpackage

// ==== rtl/sacc_top.sv ====
// Conversion control for a 10-bit successive-approximation converter
`timescale 1ns/1ps

module sacc_top #(
  parameter int TRIG_N = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire sacc_pkg::sacc_bus_type bus,
  output logic [7:0] rdata,
  input wire logic converter_power_reduction,
  input wire logic [TRIG_N-1:0] trig_src,
  input wire logic vector_taken,
  input wire logic [9:0] sar_code,
  output sacc_pkg::sacc_front_type front,
  output logic conversion_complete_flag,
  output logic conv_irq_enable
);
  import sacc_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [7:0] ps_mask(input logic [2:0] sel);
    ps_mask = 8'((16'h0001 << (sel == 3'h0 ? 3'h1 : sel)) - 16'h0001);
  endfunction

  function automatic logic is_wr(input sacc_bus_type b, input logic [3:0] a);
    is_wr = b.wr && b.addr == a;
  endfunction

  // ==========================================================
  // Registers
  // ==========================================================
  logic en_q, en_d;
  logic start_q, start_d;
  logic auto_q, auto_d;
  logic flag_q, flag_d;
  logic ie_q, ie_d;
  logic [2:0] ps_q, ps_d;
  logic [2:0] ts_q, ts_d;
  logic left_q, left_d;
  logic lock_q, lock_d;
  logic first_q, first_d;
  logic [4:0] chan_q, chan_d;
  logic [7:0] refg_q, refg_d;
  logic [9:0] res_q, res_d;
  logic [TRIG_N-1:0] tflag_q, tflag_d;
  logic [TRIG_N-1:0] tprev_q, tprev_d;
  logic [7:0] pcnt_q, pcnt_d;
  logic [4:0] cyc_q, cyc_d;
  logic samp_q, samp_d;
  logic autoconv_q, autoconv_d;
  logic [1:0] sync_q, sync_d;
  sacc_state_type st_q, st_d;
  sacc_front_type front_q, front_d;
  logic [7:0] rdata_q, rdata_d;
  logic tick, trig_edge, usable, done, long_t, sw_start;
  logic [4:0] len, shp;

  assign usable = en_q && !converter_power_reduction;
  assign tick = usable && ((pcnt_q & ps_mask(ps_q)) == ps_mask(ps_q));
  assign trig_edge = usable && auto_q && ts_q != TS_SELF
    && trig_src[ts_q] && !tprev_q[ts_q] && !tflag_q[ts_q];
  assign long_t = first_q;
  assign len = long_t ? FIRST_LEN : NORM_LEN;
  assign shp = long_t ? FIRST_SH : NORM_SH;
  assign done = st_q == ST_CONV && tick && cyc_q == len - 5'h1;
  assign sw_start = is_wr(bus, ADDR_CTRL_A) && bus.wdata[CA_START];

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    // Hold by default, except prescaler, edge history, sync, sample and read data
    en_d = en_q;
    start_d = start_q;
    auto_d = auto_q;
    flag_d = flag_q;
    ie_d = ie_q;
    ps_d = ps_q;
    ts_d = ts_q;
    left_d = left_q;
    lock_d = lock_q;
    first_d = first_q;
    chan_d = chan_q;
    refg_d = refg_q;
    res_d = res_q;
    tflag_d = tflag_q;
    tprev_d = trig_src;
    pcnt_d = usable ? pcnt_q + 8'h01 : RESET_VAL;
    cyc_d = cyc_q;
    samp_d = 1'b0;
    autoconv_d = autoconv_q;
    sync_d = {sync_q[0], 1'b0};
    st_d = st_q;
    front_d = front_q;
    rdata_d = RESET_VAL;
    if (is_wr(bus, ADDR_CTRL_A)) begin
      en_d = bus.wdata[CA_EN];
      auto_d = bus.wdata[CA_AUTO];
      ie_d = bus.wdata[CA_IE];
      ps_d = bus.wdata[CA_PS_LO +: 3];
      if (bus.wdata[CA_FLAG]) begin
        flag_d = 1'b0;
      end
      if (bus.wdata[CA_EN] && !en_q) begin
        first_d = 1'b1;
      end
    end
    if (vector_taken) begin
      flag_d = 1'b0;
    end
    if (is_wr(bus, ADDR_CTRL_B)) begin
      left_d = bus.wdata[CB_LEFT];
      ts_d = bus.wdata[CB_TS_LO +: 3];
    end
    if (is_wr(bus, ADDR_CHAN)) begin
      chan_d = bus.wdata[4:0];
      if (refg_q[RG_GAIN_ACT] && bus.wdata[4:0] != chan_q) first_d = 1'b1;
    end
    if (is_wr(bus, ADDR_REFGAIN)) begin
      refg_d = bus.wdata;
      if ((refg_q[RG_GAIN_ACT] || bus.wdata[RG_GAIN_ACT]) && bus.wdata != refg_q)
        first_d = 1'b1;
    end
    // Clear before set, so an edge in the clearing cycle is kept
    if (is_wr(bus, ADDR_TRIG_FLAGS)) begin
      tflag_d = tflag_d & ~TRIG_N'(bus.wdata);
    end
    tflag_d = tflag_d | (trig_src & ~tprev_q);
    if (!usable) begin
      st_d = ST_IDLE;
      start_d = 1'b0;
      cyc_d = 5'h0;
    end else begin
      // Selections follow the registers while idle and at a free-running restart
      if (st_q == ST_IDLE) begin
        front_d.channel = chan_d;
        front_d.reference = refg_d[2:0];
      end
      case (st_q)
        ST_IDLE: begin
          if (trig_edge) begin
            sync_d = 2'b01;
            st_d = ST_WAIT;
            start_d = 1'b1;
            autoconv_d = 1'b1;
          end else if (sw_start) begin
            st_d = ST_WAIT;
            start_d = 1'b1;
            autoconv_d = 1'b0;
          end
        end
        ST_WAIT: begin
          if (autoconv_q) begin
            if (sync_q[1]) begin
              pcnt_d = RESET_VAL;
              st_d = ST_CONV;
              cyc_d = 5'h0;
            end
          end else if (tick) begin
            st_d = ST_CONV;
            cyc_d = 5'h0;
          end
        end
        ST_CONV: begin
          if (tick) begin
            cyc_d = cyc_q + 5'h1;
            if (cyc_q == shp) begin
              samp_d = 1'b1;
            end
            if (done) begin
              flag_d = 1'b1;
              first_d = 1'b0;
              if (!lock_q) res_d = sar_code;
              if (auto_q && ts_q == TS_SELF) begin
                cyc_d = 5'h0;
                st_d = ST_CONV;
                autoconv_d = 1'b0;
                // Next free-running conversion picks up the latest selections
                front_d.channel = chan_d;
                front_d.reference = refg_d[2:0];
              end else begin
                st_d = ST_IDLE;
                start_d = 1'b0;
              end
            end
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
    front_d.sample = samp_d;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL_A: rdata_d = {en_q, start_q, auto_q, flag_q, ie_q, ps_q};
        ADDR_CTRL_B: rdata_d = {4'h0, left_q, ts_q};
        ADDR_CHAN: rdata_d = {3'h0, chan_q};
        ADDR_REFGAIN: rdata_d = refg_q;
        ADDR_RES_LOW: begin
          rdata_d = left_q ? {res_q[1:0], 6'h00} : res_q[7:0];
          lock_d = 1'b1;
        end
        ADDR_RES_HIGH: begin
          rdata_d = left_q ? res_q[9:2] : {6'h00, res_q[9:8]};
          lock_d = 1'b0;
        end
        ADDR_TRIG_FLAGS: rdata_d = 8'(tflag_q);
        default: rdata_d = RESET_VAL;
      endcase
    end
  end

  // ==========================================================
  // State registers
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 1'b0;
      start_q <= 1'b0;
      auto_q <= 1'b0;
      flag_q <= 1'b0;
      ie_q <= 1'b0;
      ps_q <= 3'h0;
      ts_q <= 3'h0;
      left_q <= 1'b0;
      lock_q <= 1'b0;
      first_q <= 1'b0;
      chan_q <= 5'h00;
      refg_q <= 8'h00;
      res_q <= 10'h000;
      tflag_q <= '0;
      tprev_q <= '0;
      pcnt_q <= 8'h00;
      cyc_q <= 5'h00;
      samp_q <= 1'b0;
      autoconv_q <= 1'b0;
      sync_q <= 2'h0;
      st_q <= ST_IDLE;
      front_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      en_q <= en_d;
      start_q <= start_d;
      auto_q <= auto_d;
      flag_q <= flag_d;
      ie_q <= ie_d;
      ps_q <= ps_d;
      ts_q <= ts_d;
      left_q <= left_d;
      lock_q <= lock_d;
      first_q <= first_d;
      chan_q <= chan_d;
      refg_q <= refg_d;
      res_q <= res_d;
      tflag_q <= tflag_d;
      tprev_q <= tprev_d;
      pcnt_q <= pcnt_d;
      cyc_q <= cyc_d;
      samp_q <= samp_d;
      autoconv_q <= autoconv_d;
      sync_q <= sync_d;
      st_q <= st_d;
      front_q <= front_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign front = front_q;
  assign conversion_complete_flag = flag_q;
  assign conv_irq_enable = ie_q;

  // ==========================================================
  // Checks
  // ==========================================================
  a_start_busy: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_q == ST_CONV |-> start_q) else $error("start bit low during conversion");
  a_done_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    done && !vector_taken |=> flag_q) else $error("flag not set at completion");
  a_lock_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    lock_q && !(bus.rd && bus.addr == ADDR_RES_HIGH) |=> $stable(res_q))
    else $error("result changed while locked");
  a_chan_frozen: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_q == ST_CONV && st_d == ST_CONV && !done |=> $stable(front_q.channel))
    else $error("channel changed mid conversion");
  a_prescale_rst: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !usable |=> pcnt_q == 8'h00) else $error("prescaler not held in reset");
  a_single_end: assert property (@(posedge ref_clk) disable iff (!reset_n)
    done && !(auto_q && ts_q == TS_SELF) |=> st_q == ST_IDLE && !start_q)
    else $error("single conversion did not end");
  a_free_run: assert property (@(posedge ref_clk) disable iff (!reset_n)
    done && auto_q && ts_q == TS_SELF |=> st_q == ST_CONV && start_q && cyc_q == 5'h0)
    else $error("free running did not restart");
  a_sync_two: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_q == ST_IDLE && trig_edge |=> ##2 (st_q == ST_CONV || !usable))
    else $error("trigger sync not two cycles");

  // Power and enable gating, idle tracking and state progress
  a_power_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    converter_power_reduction |=> st_q == ST_IDLE && !start_q)
    else $error("converter ran while power reduced");

  a_enable_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !en_q |=> pcnt_q == 8'h00 && st_q == ST_IDLE)
    else $error("converter active while disabled");

  a_idle_track: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_q == ST_IDLE && usable |=> front_q.channel == $past(chan_d))
    else $error("channel not tracked while idle");

  a_wait_busy: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_q == ST_WAIT |-> start_q)
    else $error("start bit low while waiting");

  a_wait_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_q == ST_WAIT && !autoconv_q && tick |=> st_q == ST_CONV && cyc_q == 5'h0)
    else $error("software start missed converter tick");

  a_conv_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_q == ST_CONV && !done && usable |=> st_q == ST_CONV)
    else $error("conversion cut short");

  // Conversion timing
  a_first_len: assert property (@(posedge ref_clk) disable iff (!reset_n)
    done && first_q |-> cyc_q == FIRST_LEN - 5'h1)
    else $error("first conversion length wrong");

  a_norm_len: assert property (@(posedge ref_clk) disable iff (!reset_n)
    done && !first_q |-> cyc_q == NORM_LEN - 5'h1)
    else $error("normal conversion length wrong");

  a_sample_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    samp_q |-> front_q.sample)
    else $error("sample pulse not on front end");

  // Flags and result lock
  a_flag_vector: assert property (@(posedge ref_clk) disable iff (!reset_n)
    vector_taken && !done |=> !flag_q)
    else $error("flag not cleared by vector");

  a_tflag_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tflag_q[1] && !(bus.wr && bus.addr == ADDR_TRIG_FLAGS) |=> tflag_q[1])
    else $error("trigger flag lost without clear");

  a_lock_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    bus.rd && bus.addr == ADDR_RES_LOW |=> lock_q)
    else $error("low byte read did not lock");

  a_res_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
    bus.rd && bus.addr == ADDR_RES_HIGH |=> !lock_q)
    else $error("high byte read did not unlock");
endmodule

// ==== tb/sacc_front_model.sv ====
// Behavioural analog front end that answers with a code tied to the held channel
`timescale 1ns/1ps
module sacc_front_model
  import sacc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire sacc_pkg::sacc_front_type front,
  output logic [9:0] sar_code
);
  // =====================================
  // Held code
  // Code is captured at the sample pulse, so a late channel change cannot leak in
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sar_code <= 10'h3ff;
    end else if (front.sample) begin
      sar_code <= {front.reference, 2'b01, front.channel};
    end
  end
endmodule

// ==== tb/sacc_top_tb.sv ====
// Self-checking bench for the converter conversion control block
`timescale 1ns/1ps
module sacc_top_tb;
  import sacc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  sacc_bus_type bus = '0;
  logic [7:0] rdata;
  logic pwr_red = 1'b1;
  logic [7:0] trig = 8'h00;
  logic vec = 1'b0;
  logic [9:0] sar;
  sacc_front_type front;
  logic flag;
  logic irq_en;
  int errors = 0;
  int compares = 0;
  logic [7:0] lo;
  logic [7:0] hi;
  int n;

  always #4 ref_clk = ~ref_clk;

  sacc_top #(.TRIG_N(8)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus),
    .rdata(rdata), .converter_power_reduction(pwr_red), .trig_src(trig),
    .vector_taken(vec), .sar_code(sar), .front(front),
    .conversion_complete_flag(flag), .conv_irq_enable(irq_en));
  sacc_front_model u_front (.ref_clk(ref_clk), .reset_n(reset_n), .front(front),
    .sar_code(sar));

  // =====================================
  // Shared tasks
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask
  task automatic wait_flag(output int cyc);
    cyc = 0;
    while (flag !== 1'b1 && cyc < 200) begin
      @(negedge ref_clk);
      cyc++;
    end
  endtask
  task automatic pulse_vec();
    @(posedge ref_clk);
    vec <= 1'b1;
    @(posedge ref_clk);
    vec <= 1'b0;
    @(negedge ref_clk);
  endtask
  function automatic logic [9:0] code(input logic [4:0] ch);
    return {3'h0, 2'b01, ch};
  endfunction
  task automatic end_of_test();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // =====================================
  // Scenarios
  task automatic s_reset();
    rd(ADDR_CTRL_A, lo);
    chk(lo, 8'h00);
    rd(4'hf, lo);
    chk(lo, 8'h00);
  endtask
  task automatic s_first();
    wr(ADDR_CHAN, 8'h03);
    wr(ADDR_CTRL_A, 8'h81);
    wr(ADDR_CTRL_A, 8'hc1);
    wait_flag(n);
    chk(n >= 50 && n <= 60, 1);
    rd(ADDR_CTRL_A, lo);
    chk(lo[CA_START], 0);
    rd(ADDR_RES_LOW, lo);
    rd(ADDR_RES_HIGH, hi);
    chk({hi[1:0], lo}, code(5'h03));
  endtask
  task automatic s_normal();
    wr(ADDR_CTRL_A, 8'h91);
    chk(flag, 0);
    wr(ADDR_CHAN, 8'h05);
    wr(ADDR_CTRL_A, 8'hc1);
    wait_flag(n);
    chk(n >= 28 && n <= 36, 1);
    wr(ADDR_CTRL_A, 8'hd1);
    wr(ADDR_CHAN, 8'h07);
    rd(ADDR_CTRL_A, lo);
    chk(lo[CA_START], 1);
    wait_flag(n);
    rd(ADDR_RES_LOW, lo);
    chk(lo, code(5'h05));
    pulse_vec();
    chk(flag, 0);
    wr(ADDR_CTRL_A, 8'hc1);
    wait_flag(n);
    chk(flag, 1);
    rd(ADDR_RES_HIGH, hi);
    rd(ADDR_RES_LOW, lo);
    chk({hi[1:0], lo}, code(5'h05));
    rd(ADDR_RES_HIGH, hi);
  endtask
  task automatic s_left();
    wr(ADDR_CTRL_B, 8'h08);
    wr(ADDR_CTRL_A, 8'hd9);
    chk(irq_en, 1'b1);
    wait_flag(n);
    rd(ADDR_RES_HIGH, hi);
    chk(hi, code(5'h07) >> 2);
  endtask
  task automatic s_auto();
    wr(ADDR_CTRL_B, 8'h01);
    wr(ADDR_CTRL_A, 8'hb1);
    chk(irq_en, 1'b0);
    @(posedge ref_clk);
    trig[1] <= 1'b1;
    wait_flag(n);
    chk(n <= 40, 1);
    pulse_vec();
    repeat (80) @(negedge ref_clk);
    chk(flag, 0);
    rd(ADDR_TRIG_FLAGS, lo);
    chk(lo[1], 1);
    wr(ADDR_TRIG_FLAGS, 8'h02);
    @(posedge ref_clk);
    trig[1] <= 1'b0;
    @(posedge ref_clk);
    trig[1] <= 1'b1;
    wait_flag(n);
    chk(flag, 1);
  endtask
  task automatic s_free();
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_CTRL_A, 8'hf1);
    wait_flag(n);
    rd(ADDR_CTRL_A, lo);
    chk(lo[CA_START], 1);
    pulse_vec();
    wait_flag(n);
    chk(n <= 36, 1);
  endtask

  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    pwr_red <= 1'b0;
    s_reset();
    s_first();
    s_normal();
    s_left();
    s_auto();
    s_free();
    end_of_test();
  end
endmodule
